/* core/arc_pkg.sv */
// Package: widths, register map, field positions and reset values of the range control block
package arc_pkg;
    localparam int SMP_W  = 16;                    // Converter sample width
    localparam int MAG_W  = SMP_W + 1;             // Magnitude of a filtered sample
    localparam int INT_W  = 16;                    // Integration length field
    localparam int SUM_W  = MAG_W + INT_W;         // Integrator, no overflow at 65536 samples
    localparam int ACC_W  = 16;                    // Attenuation accumulator
    localparam int STEP_W = 14;                    // Step amounts, two codes at most
    localparam int CODE_W = 3;                     // Attenuation code, 6 dB per count
    localparam int LUT_N  = 8;
    localparam int LUT_W  = 8;
    localparam int DLY_N  = 256;                   // Gain delay taps
    localparam int DLY_W  = 8;
    localparam int SHF_W  = SMP_W + LUT_N - 1;     // Shifter output, up to 7 bits of gain
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] A_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] A_IMM_THR    = 8'h04;
    localparam logic [ADDR_W-1:0] A_HOLDOFF    = 8'h08;
    localparam logic [ADDR_W-1:0] A_IMM_STEP   = 8'h0c;
    localparam logic [ADDR_W-1:0] A_UPPER_STEP = 8'h10;
    localparam logic [ADDR_W-1:0] A_LOWER_STEP = 8'h14;
    localparam logic [ADDR_W-1:0] A_BIAS       = 8'h18;
    localparam logic [ADDR_W-1:0] A_THR_UPPER  = 8'h1c;
    localparam logic [ADDR_W-1:0] A_THR_LOWER  = 8'h20;
    localparam logic [ADDR_W-1:0] A_INT_LEN    = 8'h24;
    localparam logic [ADDR_W-1:0] A_LIM_HI     = 8'h28;
    localparam logic [ADDR_W-1:0] A_LIM_LO     = 8'h2c;
    localparam logic [ADDR_W-1:0] A_DELAY      = 8'h30;
    localparam logic [ADDR_W-1:0] A_ACCUM      = 8'h34;
    localparam logic [ADDR_W-1:0] A_DC         = 8'h38;
    localparam logic [ADDR_W-1:0] A_AVG        = 8'h3c;
    localparam logic [ADDR_W-1:0] A_STATUS     = 8'h40;
    localparam logic [2:0]        A_LUT_PAGE   = 3'h3;   // 0x60..0x7c, paddr[7:5]

    // Field positions
    localparam int CTRL_BIAS_EN = 0;
    localparam int CTRL_SHIFT   = 8;
    localparam int SHIFT_W      = 5;
    localparam int ST_HOLD      = 0;
    localparam int ST_CODE      = 4;
    localparam int ST_GAIN      = 8;

    typedef struct packed {
        logic               bias_en;
        logic [SHIFT_W-1:0] avg_shift;
        logic [SMP_W-1:0]   imm_thr;
        logic [INT_W-1:0]   holdoff;
        logic [STEP_W-1:0]  immediate_step;
        logic [STEP_W-1:0]  upper_step;
        logic [STEP_W-1:0]  lower_step;
        logic [SMP_W-1:0]   bias;
        logic [SMP_W-1:0]   thr_upper;
        logic [SMP_W-1:0]   thr_lower;
        logic [INT_W-1:0]   int_len;
        logic [ACC_W-1:0]   lim_hi;
        logic [ACC_W-1:0]   lim_lo;
        logic [DLY_W-1:0]   delay;
    } arc_cfg_s;

    localparam arc_cfg_s CFG_RST = '{
        bias_en:        1'b0,
        avg_shift:      5'h08,
        imm_thr:        16'h7000,
        holdoff:        16'h0010,
        immediate_step: 14'h2000,
        upper_step:     14'h0400,
        lower_step:     14'h0400,
        bias:           16'h0000,
        thr_upper:      16'h4000,
        thr_lower:      16'h0400,
        int_len:        16'h00ff,
        lim_hi:         16'hffff,
        lim_lo:         16'h0000,
        delay:          8'h00
    };

    localparam logic [LUT_N*LUT_W-1:0] LUT_RST = 64'h0706050403020100;
endpackage

/* core/arc_range_ctrl.sv */
// Range control loop: detectors, attenuation accumulator, gain delay and APB registers
`timescale 1ns/1ps

//
// What this block does
// - Every sample magnitude is compared to an immediate threshold; above it raises attenuation.
// - Immediate detector wins over averaged decisions in the same cycle.
// - After an immediate crossing, further crossings are ignored for a hold-off count.
// - Immediate crossing adds its own programmable step, usually one code (6.02 dB).
// - Averaged path removes DC offset with a high-pass filter before magnitude.
// - Integrate-and-dump over 2 to 65536 samples, sum cleared at each dump.
// - Dumped sum is scaled down by a programmable power of two.
// - Upper and lower comparisons happen only when a period ends.
// - Average above upper threshold adds the upper step.
// - Average below lower threshold subtracts the lower step.
// - Average between thresholds adds a signed bias, which can be disabled.
// - Bias sign bit is extended across the accumulator width.
// - Step amounts are 14 bits, at most two codes (12 dB).
// - Accumulator is clamped to programmable upper and lower limits every update.
// - Only the top accumulator bits steer attenuation; low bits filter decisions.
// - Three top bits give 0 to 42 dB in 6 dB steps.
// - Code drives a left shift on the samples, 6 dB gain per count.
// - Shifter gain code is delayed 1 to 256 clocks.
// - Code indexes an 8-entry, 8-bit table that drives the attenuator bus.
// - Host may write the accumulator and read accumulator, DC offset and average.
module arc_range_ctrl #(
    parameter int DC_K = 10
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [arc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [arc_pkg::SMP_W-1:0]     adc_sample,
    output logic [arc_pkg::LUT_W-1:0]          atten_ctrl_bus,
    output logic [arc_pkg::CODE_W-1:0]         gain_code,
    output logic [arc_pkg::SHF_W-1:0]          shifted_sample
);
    import arc_pkg::*;

    localparam int DC_W = SMP_W + DC_K;

    // The filter corner needs a few bits below the sample and must not overflow the integrator
    if (DC_K < 2 || DC_K > 16) begin : g_chk
        $error("arc_range_ctrl: DC_K must lie in 2..16");
    end

    logic [SMP_W-1:0]               adc_s1;
    logic [SMP_W-1:0]               adc_s2;
    arc_cfg_s                       cfg;
    arc_cfg_s                       next_cfg;
    logic [LUT_N-1:0][LUT_W-1:0]    lut;
    logic [LUT_N-1:0][LUT_W-1:0]    next_lut;
    logic [31:0]                    next_prdata;
    logic [31:0]                    rd_val;
    logic                           mapped;
    logic                           wr;
    logic                           acc_wr;
    logic signed [DC_W-1:0]         dc_acc;
    logic signed [DC_W-1:0]         next_dc_acc;
    logic [SMP_W-1:0]               dc_val;
    logic signed [MAG_W-1:0]        x_ext;
    logic signed [MAG_W-1:0]        hp;
    logic [MAG_W-1:0]               mag_imm;
    logic [MAG_W-1:0]               mag_avg;
    logic [SUM_W-1:0]               int_sum;
    logic [SUM_W-1:0]               next_int_sum;
    logic [SUM_W-1:0]               dump;
    logic [SUM_W-1:0]               scaled;
    logic [INT_W-1:0]               int_cnt;
    logic [INT_W-1:0]               next_int_cnt;
    logic [INT_W-1:0]               int_last;
    logic                           period_end;
    logic [SMP_W-1:0]               avg_now;
    logic [SMP_W-1:0]               avg;
    logic [SMP_W-1:0]               next_avg;
    logic [INT_W-1:0]               hold_cnt;
    logic [INT_W-1:0]               next_hold_cnt;
    logic                           imm_hit;
    logic signed [ACC_W+1:0]        delta;
    logic signed [ACC_W+1:0]        acc_sum;
    logic [ACC_W-1:0]               acc;
    logic [ACC_W-1:0]               next_acc;
    logic [CODE_W-1:0]              code;
    logic [DLY_N-1:0][CODE_W-1:0]   dline;
    logic [DLY_N-1:0][CODE_W-1:0]   next_dline;
    logic [LUT_W-1:0]               next_atten;
    logic [SHF_W-1:0]               next_shifted;

    ////////////////////////////////////////////////////////////////////////////
    // Converter input
    ////////////////////////////////////////////////////////////////////////////

    // Two stages before any logic; the bus comes from the converter's own timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_s1 <= '0;
            adc_s2 <= '0;
        end else begin
            adc_s1 <= adc_sample;
            adc_s2 <= adc_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave
    ////////////////////////////////////////////////////////////////////////////

    // Zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign acc_wr  = wr && (paddr == A_ACCUM);
    assign pslverr = psel && penable && !mapped;

    // Read decode, also tells which offsets exist
    always_comb begin
        rd_val = '0;
        mapped = 1'b1;
        if (paddr == A_CTRL) begin
            rd_val[CTRL_BIAS_EN]                 = cfg.bias_en;
            rd_val[CTRL_SHIFT +: SHIFT_W]        = cfg.avg_shift;
        end else if (paddr == A_IMM_THR) begin
            rd_val[SMP_W-1:0] = cfg.imm_thr;
        end else if (paddr == A_HOLDOFF) begin
            rd_val[INT_W-1:0] = cfg.holdoff;
        end else if (paddr == A_IMM_STEP) begin
            rd_val[STEP_W-1:0] = cfg.immediate_step;
        end else if (paddr == A_UPPER_STEP) begin
            rd_val[STEP_W-1:0] = cfg.upper_step;
        end else if (paddr == A_LOWER_STEP) begin
            rd_val[STEP_W-1:0] = cfg.lower_step;
        end else if (paddr == A_BIAS) begin
            rd_val[SMP_W-1:0] = cfg.bias;
        end else if (paddr == A_THR_UPPER) begin
            rd_val[SMP_W-1:0] = cfg.thr_upper;
        end else if (paddr == A_THR_LOWER) begin
            rd_val[SMP_W-1:0] = cfg.thr_lower;
        end else if (paddr == A_INT_LEN) begin
            rd_val[INT_W-1:0] = cfg.int_len;
        end else if (paddr == A_LIM_HI) begin
            rd_val[ACC_W-1:0] = cfg.lim_hi;
        end else if (paddr == A_LIM_LO) begin
            rd_val[ACC_W-1:0] = cfg.lim_lo;
        end else if (paddr == A_DELAY) begin
            rd_val[DLY_W-1:0] = cfg.delay;
        end else if (paddr == A_ACCUM) begin
            rd_val[ACC_W-1:0] = acc;
        end else if (paddr == A_DC) begin
            rd_val[SMP_W-1:0] = dc_val;
        end else if (paddr == A_AVG) begin
            rd_val[SMP_W-1:0] = avg;
        end else if (paddr == A_STATUS) begin
            rd_val[ST_HOLD]              = (hold_cnt != '0);
            rd_val[ST_CODE +: CODE_W]    = code;
            rd_val[ST_GAIN +: CODE_W]    = gain_code;
        end else if (paddr[7:5] == A_LUT_PAGE && paddr[1:0] == 2'b00) begin
            rd_val[LUT_W-1:0] = lut[paddr[4:2]];
        end else begin
            mapped = 1'b0;
        end
    end

    // Register writes; read-only offsets ignore writes
    always_comb begin
        next_cfg    = cfg;
        next_lut    = lut;
        next_prdata = (psel && !penable) ? rd_val : prdata;
        if (wr) begin
            if (paddr == A_CTRL) begin
                next_cfg.bias_en   = pwdata[CTRL_BIAS_EN];
                next_cfg.avg_shift = pwdata[CTRL_SHIFT +: SHIFT_W];
            end else if (paddr == A_IMM_THR) begin
                next_cfg.imm_thr = pwdata[SMP_W-1:0];
            end else if (paddr == A_HOLDOFF) begin
                next_cfg.holdoff = pwdata[INT_W-1:0];
            end else if (paddr == A_IMM_STEP) begin
                next_cfg.immediate_step = pwdata[STEP_W-1:0];
            end else if (paddr == A_UPPER_STEP) begin
                next_cfg.upper_step = pwdata[STEP_W-1:0];
            end else if (paddr == A_LOWER_STEP) begin
                next_cfg.lower_step = pwdata[STEP_W-1:0];
            end else if (paddr == A_BIAS) begin
                next_cfg.bias = pwdata[SMP_W-1:0];
            end else if (paddr == A_THR_UPPER) begin
                next_cfg.thr_upper = pwdata[SMP_W-1:0];
            end else if (paddr == A_THR_LOWER) begin
                next_cfg.thr_lower = pwdata[SMP_W-1:0];
            end else if (paddr == A_INT_LEN) begin
                next_cfg.int_len = pwdata[INT_W-1:0];
            end else if (paddr == A_LIM_HI) begin
                next_cfg.lim_hi = pwdata[ACC_W-1:0];
            end else if (paddr == A_LIM_LO) begin
                next_cfg.lim_lo = pwdata[ACC_W-1:0];
            end else if (paddr == A_DELAY) begin
                next_cfg.delay = pwdata[DLY_W-1:0];
            end else if (paddr[7:5] == A_LUT_PAGE && paddr[1:0] == 2'b00) begin
                next_lut[paddr[4:2]] = pwdata[LUT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg    <= CFG_RST;
            lut    <= LUT_RST;
            prdata <= '0;
        end else begin
            cfg    <= next_cfg;
            lut    <= next_lut;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detectors
    ////////////////////////////////////////////////////////////////////////////

    // Magnitudes; one extra bit so the most negative sample does not wrap
    always_comb begin
        x_ext   = $signed({adc_s2[SMP_W-1], adc_s2});
        mag_imm = x_ext[MAG_W-1] ? MAG_W'(-x_ext) : MAG_W'(x_ext);
        dc_val  = dc_acc[DC_W-1 -: SMP_W];
        hp      = x_ext - $signed({dc_val[SMP_W-1], dc_val});
        mag_avg = hp[MAG_W-1] ? MAG_W'(-hp) : MAG_W'(hp);
    end

    // Leaky DC estimate; corner set by DC_K, slow enough to pass the signal
    always_comb begin
        next_dc_acc = dc_acc + DC_W'(hp);
    end

    // Integrate and dump; a length field of 0 still gives two samples
    always_comb begin
        int_last     = (cfg.int_len == '0) ? INT_W'(1) : cfg.int_len;
        period_end   = (int_cnt >= int_last);
        dump         = int_sum + SUM_W'(mag_avg);
        next_int_sum = period_end ? '0 : dump;
        next_int_cnt = period_end ? '0 : int_cnt + INT_W'(1);
        scaled       = dump >> cfg.avg_shift;
        avg_now      = (|scaled[SUM_W-1:SMP_W]) ? '1 : scaled[SMP_W-1:0];
        next_avg     = period_end ? avg_now : avg;
    end

    // Hold-off: immediate detector sleeps while the counter runs
    always_comb begin
        imm_hit = (mag_imm > MAG_W'(cfg.imm_thr)) && (hold_cnt == '0);
        if (imm_hit) begin
            next_hold_cnt = cfg.holdoff;
        end else if (hold_cnt != '0) begin
            next_hold_cnt = hold_cnt - INT_W'(1);
        end else begin
            next_hold_cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dc_acc   <= '0;
            int_sum  <= '0;
            int_cnt  <= '0;
            avg      <= '0;
            hold_cnt <= '0;
        end else begin
            dc_acc   <= next_dc_acc;
            int_sum  <= next_int_sum;
            int_cnt  <= next_int_cnt;
            avg      <= next_avg;
            hold_cnt <= next_hold_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Attenuation accumulator
    ////////////////////////////////////////////////////////////////////////////

    // Immediate crossing first, averaged decisions only at period end
    always_comb begin
        delta = '0;
        if (imm_hit) begin
            delta = $signed({4'h0, cfg.immediate_step});
        end else if (period_end) begin
            if (avg_now > cfg.thr_upper) begin
                delta = $signed({4'h0, cfg.upper_step});
            end else if (avg_now < cfg.thr_lower) begin
                delta = -$signed({4'h0, cfg.lower_step});
            end else if (cfg.bias_en) begin
                delta = $signed({{2{cfg.bias[SMP_W-1]}}, cfg.bias});
            end
        end
    end

    // Host load wins over detectors; result always clamped, never wraps
    always_comb begin
        if (acc_wr) begin
            acc_sum = $signed({2'b00, pwdata[ACC_W-1:0]});
        end else begin
            acc_sum = $signed({2'b00, acc}) + delta;
        end
        if (acc_sum > $signed({2'b00, cfg.lim_hi})) begin
            next_acc = cfg.lim_hi;
        end else if (acc_sum < $signed({2'b00, cfg.lim_lo})) begin
            next_acc = cfg.lim_lo;
        end else begin
            next_acc = acc_sum[ACC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Attenuator bus, gain delay and shifter
    ////////////////////////////////////////////////////////////////////////////

    // Low bits are a filter; only the top three steer anything
    assign code = acc[ACC_W-1 -: CODE_W];

    // Delay tap N-1 gives N clocks from accumulator change to shifter
    assign gain_code = dline[cfg.delay];

    always_comb begin
        next_dline   = {dline[DLY_N-2:0], code};
        next_atten   = lut[code];
        next_shifted = SHF_W'($signed(adc_s2)) << gain_code;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dline          <= '0;
            atten_ctrl_bus <= '0;
            shifted_sample <= '0;
        end else begin
            dline          <= next_dline;
            atten_ctrl_bus <= next_atten;
            shifted_sample <= next_shifted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_delay_steady;
        (cfg.delay == 8'h03) [*5];
    endsequence

    a_imm_step_add: assert property (imm_hit && !acc_wr && !wr
        && ({2'b00, acc} + {4'h0, cfg.immediate_step} <= {2'b00, cfg.lim_hi}) && acc >= cfg.lim_lo
        |=> acc == $past(acc) + ACC_W'($past(cfg.immediate_step)))
        else $error("immediate crossing did not add its step");

    a_imm_priority: assert property (imm_hit && period_end |-> delta == $signed({4'h0, cfg.immediate_step}))
        else $error("averaged decision beat the immediate detector");

    a_holdoff_quiet: assert property (imm_hit && cfg.holdoff != '0 |=>
        hold_cnt == $past(cfg.holdoff) ##0 (!imm_hit) [*1])
        else $error("immediate detector not held off");

    // A limit write pulls acc in one edge later, so the cycle after a write is left out
    a_mid_period: assert property (!imm_hit && !period_end && !wr && !$past(wr) |=> $stable(acc))
        else $error("accumulator moved inside an integration period");

    a_dump_clear: assert property (period_end |=> int_sum == '0 && int_cnt == '0)
        else $error("integrator not cleared at dump");

    a_bias_off: assert property (period_end && !imm_hit && !cfg.bias_en && !wr
        && !$past(wr) && avg_now <= cfg.thr_upper && avg_now >= cfg.thr_lower |=> $stable(acc))
        else $error("bias applied while disabled");

    a_acc_limits: assert property (cfg.lim_lo <= cfg.lim_hi && $stable(cfg.lim_lo)
        && $stable(cfg.lim_hi) && !$past(wr) |-> acc <= cfg.lim_hi && acc >= cfg.lim_lo)
        else $error("accumulator outside its limits");

    a_gain_delay: assert property (s_delay_steady |-> gain_code == $past(code, 4))
        else $error("gain code not delayed by four clocks");

    a_upper_step: assert property (period_end && !imm_hit && !wr && avg_now > cfg.thr_upper
        && {2'b00, acc} + {4'h0, cfg.upper_step} <= {2'b00, cfg.lim_hi} && acc >= cfg.lim_lo
        |=> acc == $past(acc) + ACC_W'($past(cfg.upper_step)))
        else $error("upper step not added");
endmodule

/* tb/arc_adc_model.sv */
// Partner model: converter fed through a stepped attenuator
`timescale 1ns/1ps
module arc_adc_model (
    input  wire logic [15:0]               rf_amp,
    input  wire logic                      pclk,
    input  wire logic [arc_pkg::LUT_W-1:0] atten_ctrl_bus,
    output logic [arc_pkg::SMP_W-1:0]      adc_sample
);
    import arc_pkg::*;
    logic             flip = 1'b0;
    logic [SMP_W-1:0] mag;
    // Low bits of the control word pick a 6 dB step
    assign mag = rf_amp >> atten_ctrl_bus[2:0];
    // Alternating sign keeps the carrier free of DC
    always @(posedge pclk) begin
        flip <= ~flip;
        adc_sample <= flip ? -mag : mag;
    end
    initial adc_sample = '0;
endmodule

/* tb/tb.sv */
// Testbench: register access, averaged and immediate range control scenarios
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module tb;
    import arc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0]  paddr = 0, atten_ctrl_bus;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] adc_sample, rf_amp = 0;
    logic [2:0]  gain_code;
    logic [22:0] shf;
    int          n_errors = 0, n_checks = 0;
    arc_range_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_sample(adc_sample), .atten_ctrl_bus(atten_ctrl_bus), .gain_code(gain_code), .shifted_sample(shf));
    arc_adc_model adc_u (.pclk(pclk), .rf_amp(rf_amp), .atten_ctrl_bus(atten_ctrl_bus), .adc_sample(adc_sample));
    ////////////////////////////////////////////////////////////////////////
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk_acc(input logic [15:0] e);
        apb(1'b0, A_ACCUM, 32'h0);
        `CHK("accum", {16'h0, e}, rd)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk_acc(16'h0);
        apb(1'b0, 8'h6c, 32'h0);
        `CHK("lut3", 32'h3, rd)
        apb(1'b0, 8'h50, 32'h0);
        `CHK("unmapped", 1'b1, er)
        `CHK("gain rst", 3'h0, gain_code)
        $display("t_reset done");
    endtask
    // Averaged path: 16-sample periods, shift 4, limits stop the ramps
    task automatic t_avg;
        wr(A_INT_LEN, 32'hf);
        wr(A_CTRL, 32'h400);
        wr(A_ACCUM, 32'h1800);
        wr(A_LIM_LO, 32'h1400);
        rf_amp <= 16'h0100;
        repeat (400) @(posedge pclk);
        chk_acc(16'h1400);
        apb(1'b0, A_AVG, 32'h0);
        `CHK("avg", 1'b1, rd >= 32'he0 && rd <= 32'h120)
        wr(A_LIM_LO, 32'h0);
        wr(A_ACCUM, 32'h0);
        wr(A_LIM_HI, 32'h800);
        rf_amp <= 16'h5000;
        repeat (400) @(posedge pclk);
        chk_acc(16'h0800);
        rf_amp <= 16'h1000;
        repeat (40) @(posedge pclk);
        wr(A_LIM_HI, 32'hffff);
        wr(A_LIM_LO, 32'hf00);
        wr(A_ACCUM, 32'h1000);
        repeat (400) @(posedge pclk);
        chk_acc(16'h1000);
        wr(A_BIAS, 32'hff00);
        wr(A_CTRL, 32'h401);
        repeat (400) @(posedge pclk);
        chk_acc(16'h0f00);
        $display("t_avg done");
    endtask
    // Immediate path; table entries 1 and 2 zeroed so the level stays high
    task automatic t_imm;
        wr(A_CTRL, 32'h400);
        wr(A_THR_UPPER, 32'hffff);
        wr(A_LIM_LO, 32'h0);
        wr(A_HOLDOFF, 32'h14);
        wr(A_DELAY, 32'h3);
        wr(8'h64, 32'h0);
        wr(8'h68, 32'h0);
        wr(A_ACCUM, 32'h0);
        rf_amp <= 16'h7fff;
        repeat (12) @(posedge pclk);
        chk_acc(16'h2000);
        `CHK("gain one", 3'h1, gain_code)
        `CHK("bus one", 8'h0, atten_ctrl_bus)
        wr(A_LIM_HI, 32'h5000);
        repeat (200) @(posedge pclk);
        chk_acc(16'h5000);
        `CHK("gain two", 3'h2, gain_code)
        `CHK("shifted", 1'b1, shf == 23'h1fffc || shf == 23'h7e0004)
        apb(1'b0, A_STATUS, 32'h0);
        `CHK("status", 32'h220, rd & 32'h770)
        apb(1'b0, A_DC, 32'h0);
        `CHK("dc small", 1'b1, rd[15:0] < 16'h100 || rd[15:0] >= 16'hff00)
        $display("t_imm done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_avg();
        t_imm();
        conclude();
    end
    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        repeat (50000) @(posedge pclk);
        n_errors++;
        conclude();
    end
endmodule
